// *** inc/ehc_params.svh ***
// Offsets, field positions, reset values and byte counts of the header comparator.
// Assumes inclusion by bare name from the core and the bench.
`ifndef EHC_PARAMS_SVH
`define EHC_PARAMS_SVH
// -----------------------------------------------------------------------------
// Register byte offsets
// -----------------------------------------------------------------------------
`define EHC_OFF_CTRL      8'h00
`define EHC_OFF_TPID      8'h04
`define EHC_OFF_TYPEVAL   8'h08
`define EHC_OFF_TAGCMP    8'h0C
`define EHC_OFF_STATUS    8'h10
`define EHC_OFF_FLOW_BASE 8'h40
// -----------------------------------------------------------------------------
// Control register and flow word field positions
// -----------------------------------------------------------------------------
`define EHC_CTRL_SIG_LSB  8
`define EHC_CTRL_BB_BIT   16
`define EHC_CTRL_TCE_BIT  17
`define EHC_CTRL_T1_BIT   18
`define EHC_CTRL_TAGE_BIT 19
`define EHC_FLOW_EN_BIT   31
// -----------------------------------------------------------------------------
// Reset values and fixed protocol values
// -----------------------------------------------------------------------------
`define EHC_RST_TPID      16'h8A88
`define EHC_CTAG_TPID     16'h8100
`define EHC_LEN_LIMIT     16'h0600
`define EHC_SAP_A         8'hAA
`define EHC_SAP_B         8'hAB
`define EHC_LLC_CTL       8'h03
`define EHC_OUI_ZERO      24'h000000
`define EHC_OUI_ALT       24'h0000F8
// -----------------------------------------------------------------------------
// Header byte counts (index of last byte in each field)
// -----------------------------------------------------------------------------
`define EHC_ADDR_LAST     4'hB
`define EHC_LLC_LAST      4'h2
`define EHC_OUI_LAST      4'h2
`define EHC_ITAG_LAST     4'h3
`endif

// *** inc/ehc_pkg.sv ***
// Types shared by the header comparator.
// Assumes nothing beyond a SystemVerilog compiler.
package ehc_pkg;
	// Parser states, one-hot
	typedef enum logic [6:0] {
		ST_IDLE = 7'b0000001,
		ST_ADDR = 7'b0000010,
		ST_TYPE = 7'b0000100,
		ST_TAG  = 7'b0001000,
		ST_LLC  = 7'b0010000,
		ST_OUI  = 7'b0100000,
		ST_ITAG = 7'b1000000
	} ehc_state_t;
endpackage

// *** core/ehc_cmp.sv ***
// Ethernet / LLC / SNAP header comparator stage with AHB-Lite register slave.
// Assumes at most one header byte per clock, qualified by frame_valid_i, with frame_sof_i on the header's first byte,
// and a single AHB-Lite master issuing word transfers.
`include "ehc_params.svh"
module ehc_cmp #(
	parameter int NUM_FLOWS = 8,
	parameter bit FIRST_STAGE = 1'b1,
	parameter logic [15:0] ITAG_TPID = 16'h88E7
) (
	input wire logic ref_clk_i,
	input wire logic sys_rst_i,
	input wire logic hsel_i,
	input wire logic [31:0] haddr_i,
	input wire logic [1:0] htrans_i,
	input wire logic hwrite_i,
	input wire logic [2:0] hsize_i,
	input wire logic [31:0] hwdata_i,
	input wire logic hready_i,
	output logic hreadyout_o,
	output logic hresp_o,
	output logic [31:0] hrdata_o,
	input wire logic frame_valid_i,
	input wire logic frame_sof_i,
	input wire logic [7:0] frame_byte_i,
	output logic result_valid_o,
	output logic match_o,
	output logic [7:0] next_offset_o,
	output logic [2:0] next_stage_o,
	output logic [4:0] sig_offset_o,
	output logic [NUM_FLOWS-1:0] flow_hit_o
);
	// -------------------------------------------------------------------------
	// Register state
	// -------------------------------------------------------------------------
	logic [2:0] next_stage_selector_r;
	logic [4:0] signature_field_start_r;
	logic [15:0] tag_protocol_id_value_r;
	logic backbone_bridging_enable_r;
	logic type_compare_enable_r;
	logic [15:0] type_compare_value_r;
	logic type1_enable_r;
	logic tag_check_enable_r;
	logic [11:0] tag_match_r;
	logic [11:0] tag_mask_r;
	logic [31:0] flow_cfg_r [NUM_FLOWS];
	logic wr_pend_r;
	logic [7:0] wr_addr_r;
	logic [31:0] rdata_r;
	logic bb_en;

	// Second stage never runs backbone mode
	assign bb_en = FIRST_STAGE & backbone_bridging_enable_r;

	// -------------------------------------------------------------------------
	// AHB-Lite slave, zero wait states, always OKAY
	// -------------------------------------------------------------------------
	logic addr_ok;
	logic [31:0] rd_mux;
	logic [7:0] flow_idx;
	assign addr_ok = hsel_i & hready_i & htrans_i[1];
	assign hreadyout_o = 1'b1;
	assign hresp_o = 1'b0;
	assign hrdata_o = rdata_r;
	assign flow_idx = (haddr_i[7:0] - `EHC_OFF_FLOW_BASE) >> 2;

	// Read data is fetched in the address phase so it stands from a flop
	always_comb begin
		rd_mux = 32'h00000000;
		if (haddr_i[7:0] == `EHC_OFF_CTRL) begin
			rd_mux[2:0] = next_stage_selector_r;
			rd_mux[`EHC_CTRL_SIG_LSB +: 5] = signature_field_start_r;
			rd_mux[`EHC_CTRL_BB_BIT] = bb_en;
			rd_mux[`EHC_CTRL_TCE_BIT] = type_compare_enable_r;
			rd_mux[`EHC_CTRL_T1_BIT] = type1_enable_r;
			rd_mux[`EHC_CTRL_TAGE_BIT] = tag_check_enable_r;
		end else if (haddr_i[7:0] == `EHC_OFF_TPID) begin
			rd_mux[15:0] = tag_protocol_id_value_r;
		end else if (haddr_i[7:0] == `EHC_OFF_TYPEVAL) begin
			rd_mux[15:0] = type_compare_value_r;
		end else if (haddr_i[7:0] == `EHC_OFF_TAGCMP) begin
			rd_mux = {4'h0, tag_mask_r, 4'h0, tag_match_r};
		end else if (haddr_i[7:0] == `EHC_OFF_STATUS) begin
			rd_mux = {next_offset_o, {(16-NUM_FLOWS){1'b0}}, flow_hit_o, 7'h00, match_o};
		end else if (haddr_i[7:0] >= `EHC_OFF_FLOW_BASE && flow_idx < 8'(NUM_FLOWS)) begin
			rd_mux = flow_cfg_r[flow_idx[$clog2(NUM_FLOWS)-1:0]];
		end
	end

	// Address phase capture
	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			wr_pend_r <= 1'b0;
			wr_addr_r <= 8'h00;
			rdata_r <= 32'h00000000;
		end else begin
			wr_pend_r <= addr_ok & hwrite_i;
			if (addr_ok) begin
				wr_addr_r <= haddr_i[7:0];
			end
			if (addr_ok & ~hwrite_i) begin
				rdata_r <= rd_mux;
			end
		end
	end

	// Shared next-protocol settings, written in the data phase
	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			next_stage_selector_r <= 3'h0;
			signature_field_start_r <= 5'h00;
			tag_protocol_id_value_r <= `EHC_RST_TPID;
			backbone_bridging_enable_r <= 1'b0;
			type_compare_enable_r <= 1'b0;
			type_compare_value_r <= 16'h0000;
			type1_enable_r <= 1'b0;
			tag_check_enable_r <= 1'b0;
			tag_match_r <= 12'h000;
			tag_mask_r <= 12'h000;
		end else if (wr_pend_r) begin
			if (wr_addr_r == `EHC_OFF_CTRL) begin
				next_stage_selector_r <= hwdata_i[2:0];
				signature_field_start_r <= hwdata_i[`EHC_CTRL_SIG_LSB +: 5];
				backbone_bridging_enable_r <= hwdata_i[`EHC_CTRL_BB_BIT];
				type_compare_enable_r <= hwdata_i[`EHC_CTRL_TCE_BIT];
				type1_enable_r <= hwdata_i[`EHC_CTRL_T1_BIT];
				tag_check_enable_r <= hwdata_i[`EHC_CTRL_TAGE_BIT];
			end
			if (wr_addr_r == `EHC_OFF_TPID) begin
				tag_protocol_id_value_r <= hwdata_i[15:0];
			end
			if (wr_addr_r == `EHC_OFF_TYPEVAL) begin
				type_compare_value_r <= hwdata_i[15:0];
			end
			if (wr_addr_r == `EHC_OFF_TAGCMP) begin
				tag_match_r <= hwdata_i[11:0];
				tag_mask_r <= hwdata_i[27:16];
			end
		end
	end

	// -------------------------------------------------------------------------
	// Per-flow settings and flow comparison
	// -------------------------------------------------------------------------
	logic [11:0] tag1_vid_r;
	logic [1:0] tags_r;
	logic [NUM_FLOWS-1:0] flow_now;
	genvar gi;
	generate
		for (gi = 0; gi < NUM_FLOWS; gi++) begin : g_flow
			// Flow word: enable, 12-bit mask, 12-bit tag match
			always_ff @(posedge ref_clk_i) begin
				if (sys_rst_i) begin
					flow_cfg_r[gi] <= 32'h00000000;
				end else if (wr_pend_r && wr_addr_r == 8'(`EHC_OFF_FLOW_BASE + 4 * gi)) begin
					flow_cfg_r[gi] <= hwdata_i & 32'h8FFF0FFF;
				end
			end
			// Each flow tested on its own; untagged frames hit only where the masked match bits are zero
			assign flow_now[gi] = flow_cfg_r[gi][`EHC_FLOW_EN_BIT] &
				(((tag1_vid_r ^ flow_cfg_r[gi][11:0]) & flow_cfg_r[gi][27:16]) == 12'h000);
		end
	endgenerate

	// -------------------------------------------------------------------------
	// Header parser
	// -------------------------------------------------------------------------
	ehc_pkg::ehc_state_t state_r;
	ehc_pkg::ehc_state_t state_nxt;
	logic [7:0] pos_r;
	logic [7:0] cur_idx;
	logic [3:0] fcnt_r;
	logic [7:0] hi_r;
	logic [23:0] oui_r;
	logic llc_r;
	logic snap_r;
	logic [15:0] field;
	logic is_ctag;
	logic is_stag;
	logic is_itag;
	logic is_len;
	logic [1:0] tag_lim;
	logic tag_ok;
	logic fin;
	logic fin_ok;
	logic sap_ok;

	assign cur_idx = frame_sof_i ? 8'h00 : pos_r;
	assign field = {hi_r, frame_byte_i};
	assign is_ctag = field == `EHC_CTAG_TPID;
	assign is_stag = field == tag_protocol_id_value_r;
	assign is_itag = bb_en & (field == ITAG_TPID);
	assign is_len = type1_enable_r & (field < `EHC_LEN_LIMIT) & ~snap_r & ~llc_r;
	// Backbone first part carries at most one tag before the instance tag
	assign tag_lim = bb_en ? 2'd1 : 2'd2;
	assign tag_ok = ~tag_check_enable_r | (tags_r != 2'd0 &&
		((tag1_vid_r ^ tag_match_r) & tag_mask_r) == 12'h000);
	assign sap_ok = frame_byte_i == `EHC_SAP_A || frame_byte_i == `EHC_SAP_B;

	// Next state and result decision
	always_comb begin
		state_nxt = state_r;
		fin = 1'b0;
		fin_ok = 1'b0;
		if (frame_valid_i && frame_sof_i) begin
			state_nxt = ehc_pkg::ST_ADDR;
		end else if (frame_valid_i) begin
			unique case (state_r)
				ehc_pkg::ST_IDLE: begin
					state_nxt = ehc_pkg::ST_IDLE;
				end
				ehc_pkg::ST_ADDR: begin
					if (fcnt_r == `EHC_ADDR_LAST) begin
						state_nxt = ehc_pkg::ST_TYPE;
					end
				end
				ehc_pkg::ST_TYPE: begin
					if (fcnt_r[0]) begin
						if (is_itag && !snap_r && !llc_r) begin
							state_nxt = ehc_pkg::ST_ITAG;
						end else if (is_ctag || is_stag) begin
							// A tag after SNAP is parsed the same way
							if (tags_r == tag_lim) begin
								fin = 1'b1;
							end else begin
								state_nxt = ehc_pkg::ST_TAG;
							end
						end else if (is_len) begin
							if (bb_en) begin
								fin = 1'b1;
							end else begin
								state_nxt = ehc_pkg::ST_LLC;
							end
						end else begin
							// Last type field decides the next protocol
							fin = 1'b1;
							fin_ok = ~bb_en & tag_ok &
								~(type_compare_enable_r & ~llc_r & (field != type_compare_value_r));
						end
						if (fin) begin
							state_nxt = ehc_pkg::ST_IDLE;
						end
					end
				end
				ehc_pkg::ST_TAG: begin
					if (fcnt_r[0]) begin
						state_nxt = ehc_pkg::ST_TYPE;
					end
				end
				ehc_pkg::ST_LLC: begin
					if ((fcnt_r == `EHC_LLC_LAST) ? (frame_byte_i != `EHC_LLC_CTL) : !sap_ok) begin
						fin = 1'b1;
						state_nxt = ehc_pkg::ST_IDLE;
					end else if (fcnt_r == `EHC_LLC_LAST) begin
						state_nxt = ehc_pkg::ST_OUI;
					end
				end
				ehc_pkg::ST_OUI: begin
					if (fcnt_r == `EHC_OUI_LAST) begin
						if ({oui_r[15:0], frame_byte_i} == `EHC_OUI_ZERO ||
							{oui_r[15:0], frame_byte_i} == `EHC_OUI_ALT) begin
							state_nxt = ehc_pkg::ST_TYPE;
						end else begin
							fin = 1'b1;
							state_nxt = ehc_pkg::ST_IDLE;
						end
					end
				end
				ehc_pkg::ST_ITAG: begin
					if (fcnt_r == `EHC_ITAG_LAST) begin
						fin = 1'b1;
						fin_ok = tag_ok;
						state_nxt = ehc_pkg::ST_IDLE;
					end
				end
			endcase
		end
	end

	// State, position and field counters
	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			state_r <= ehc_pkg::ST_IDLE;
			pos_r <= 8'h00;
			fcnt_r <= 4'h0;
		end else if (frame_valid_i) begin
			state_r <= state_nxt;
			pos_r <= cur_idx + 8'h01;
			if (frame_sof_i) begin
				fcnt_r <= 4'h1;
			end else if (state_nxt != state_r) begin
				fcnt_r <= 4'h0;
			end else begin
				fcnt_r <= fcnt_r + 4'h1;
			end
		end
	end

	// Field capture: high byte, organisation id, first tag, flags
	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			hi_r <= 8'h00;
			oui_r <= 24'h000000;
			tag1_vid_r <= 12'h000;
			tags_r <= 2'd0;
			llc_r <= 1'b0;
			snap_r <= 1'b0;
		end else if (frame_valid_i) begin
			hi_r <= frame_byte_i;
			if (frame_sof_i) begin
				tags_r <= 2'd0;
				tag1_vid_r <= 12'h000;
				llc_r <= 1'b0;
				snap_r <= 1'b0;
			end else begin
				if (state_r == ehc_pkg::ST_TYPE && state_nxt == ehc_pkg::ST_TAG) begin
					tags_r <= tags_r + 2'd1;
				end
				if (state_r == ehc_pkg::ST_TAG && fcnt_r[0] && tags_r == 2'd1) begin
					tag1_vid_r <= {hi_r[3:0], frame_byte_i};
				end
				if (state_nxt == ehc_pkg::ST_LLC && state_r == ehc_pkg::ST_TYPE) begin
					llc_r <= 1'b1;
				end
				if (state_r == ehc_pkg::ST_OUI) begin
					oui_r <= {oui_r[15:0], frame_byte_i};
					snap_r <= state_nxt == ehc_pkg::ST_TYPE;
				end
			end
		end
	end

	// -------------------------------------------------------------------------
	// Result to the engine controller
	// -------------------------------------------------------------------------
	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			result_valid_o <= 1'b0;
			match_o <= 1'b0;
			next_offset_o <= 8'h00;
			next_stage_o <= 3'h0;
			sig_offset_o <= 5'h00;
			flow_hit_o <= '0;
		end else begin
			result_valid_o <= fin;
			if (fin) begin
				// Failure carries no match so the frame is left untouched
				match_o <= fin_ok;
				next_offset_o <= cur_idx + 8'h01;
				next_stage_o <= next_stage_selector_r;
				sig_offset_o <= signature_field_start_r;
				flow_hit_o <= fin_ok ? flow_now : '0;
			end
		end
	end

	// -------------------------------------------------------------------------
	// Checks
	// -------------------------------------------------------------------------
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (sys_rst_i);

	chk_bb_stage_two: assert property (state_nxt == ehc_pkg::ST_ITAG && state_r != ehc_pkg::ST_ITAG |-> FIRST_STAGE && backbone_bridging_enable_r)
		else $error("Instance tag parsed without first-stage backbone mode");
	chk_offset_after_type: assert property (fin |=> next_offset_o == $past(cur_idx) + 8'h01)
		else $error("Next offset not after final field");
	chk_fail_no_match: assert property (fin && !fin_ok |=> result_valid_o && !match_o && flow_hit_o == '0)
		else $error("Failed header reported a match");
	chk_type_compare: assert property (fin && state_r == ehc_pkg::ST_TYPE && type_compare_enable_r && !llc_r
		&& field != type_compare_value_r |-> !fin_ok)
		else $error("Type mismatch accepted");
	chk_llc_control: assert property (frame_valid_i && !frame_sof_i && state_r == ehc_pkg::ST_LLC
		&& fcnt_r == 4'h2 && frame_byte_i != 8'h03 |=> state_r == ehc_pkg::ST_IDLE)
		else $error("Bad LLC control byte accepted");
	chk_snap_after_llc: assert property (state_r != ehc_pkg::ST_OUI ##1 state_r == ehc_pkg::ST_OUI
		|-> $past(state_r) == ehc_pkg::ST_LLC)
		else $error("SNAP entered without LLC");
	chk_tag_limit: assert property (tags_r <= tag_lim)
		else $error("Too many tags parsed");
	chk_length_path: assert property (frame_valid_i && !frame_sof_i && state_r == ehc_pkg::ST_TYPE && fcnt_r[0]
		&& !type1_enable_r && !is_ctag && !is_stag && !is_itag |-> fin)
		else $error("Length path taken with Type I off");
	chk_result_pulse: assert property (result_valid_o |=> !result_valid_o)
		else $error("Result valid longer than one cycle");
	chk_read_one_cycle: assert property (addr_ok && !hwrite_i |=> rdata_r == $past(rd_mux))
		else $error("Read data not taken in address phase");
endmodule // ehc_cmp

// *** bench/ehc_frame_src.sv ***
// Behavioural header-byte source standing in for the engine controller side.
// Assumes one byte per clock, or one byte every other clock when slow_i is high.
module ehc_frame_src (
	input wire logic ref_clk_i,
	input wire logic sys_rst_i,
	input wire logic go_i,
	input wire logic slow_i,
	input wire logic [5:0] len_i,
	input wire logic [255:0] data_i,
	output logic frame_valid_o,
	output logic frame_sof_o,
	output logic [7:0] frame_byte_o,
	output logic busy_o
);
	timeunit 1ns;
	timeprecision 100ps;
	// -------------------------------------------------------------------------
	// Streaming
	// -------------------------------------------------------------------------
	logic [5:0] idx_r;
	logic gap_r;
	// Byte line toggles when idle so a stale byte is never mistaken for data
	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			busy_o <= 1'b0;
			idx_r <= 6'h00;
			gap_r <= 1'b0;
			frame_valid_o <= 1'b0;
			frame_sof_o <= 1'b0;
			frame_byte_o <= 8'h5A;
		end else if (busy_o && (gap_r || !slow_i)) begin
			frame_valid_o <= 1'b1;
			frame_sof_o <= (idx_r == 6'h00);
			frame_byte_o <= data_i[8*idx_r+:8];
			idx_r <= idx_r + 6'h01;
			gap_r <= 1'b0;
			busy_o <= (idx_r != len_i - 6'h01);
		end else begin
			frame_valid_o <= 1'b0;
			frame_sof_o <= 1'b0;
			frame_byte_o <= ~frame_byte_o;
			gap_r <= busy_o;
			if (go_i && !busy_o) begin
				busy_o <= 1'b1;
				idx_r <= 6'h00;
			end
		end
	end
endmodule // ehc_frame_src

// *** bench/ethernet_header_next_protocol_cmp_tb.sv ***
// Self-checking bench for the header comparator: AHB-Lite register access and header frames.
// Assumes the comparator core, its package, its parameter header and the frame source model.
`include "ehc_params.svh"
module ethernet_header_next_protocol_cmp_tb;
	timeunit 1ns;
	timeprecision 100ps;
	logic ref_clk_i = 1'b0;
	logic sys_rst_i = 1'b1;
	logic hsel = 1'b0, hwrite = 1'b0, hreadyout, hresp;
	logic [1:0] htrans = 2'h0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
	logic fr_go = 1'b0, fr_slow = 1'b0, fr_busy, fv, fs;
	logic [5:0] fr_len = 6'h00;
	logic [255:0] fr_data = '0;
	logic [7:0] fb, noff;
	logic rv, mt;
	logic [2:0] nst, exp_st;
	logic [4:0] sgo, exp_sg;
	logic [7:0] fh, exp_fh;
	logic [7:0] q[$];
	int num_errors = 0, checked = 0;
	// -------------------------------------------------------------------------
	// Clock and instances
	// -------------------------------------------------------------------------
	initial forever #12.5 ref_clk_i = ~ref_clk_i;
	ehc_cmp #(.NUM_FLOWS(8), .FIRST_STAGE(1'b1)) ehc_cmp_i (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i),
		.hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize),
		.hwdata_i(hwdata), .hready_i(hreadyout), .hreadyout_o(hreadyout), .hresp_o(hresp), .hrdata_o(hrdata),
		.frame_valid_i(fv), .frame_sof_i(fs), .frame_byte_i(fb), .result_valid_o(rv), .match_o(mt),
		.next_offset_o(noff), .next_stage_o(nst), .sig_offset_o(sgo), .flow_hit_o(fh));
	ehc_frame_src ehc_frame_src_i (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .go_i(fr_go),
		.slow_i(fr_slow), .len_i(fr_len), .data_i(fr_data), .frame_valid_o(fv), .frame_sof_o(fs),
		.frame_byte_o(fb), .busy_o(fr_busy));
	// -------------------------------------------------------------------------
	// Reporting and bus tasks
	// -------------------------------------------------------------------------
	task close_out();
		$display("errors %0d, checks %0d", num_errors, checked);
		if (num_errors == 0 && checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task chk(input logic ok, input string msg);
		checked++;
		if (ok !== 1'b1) begin
			num_errors++;
			$display("[ERR] %0t %s", $time, msg);
		end
	endtask
	// Holds each phase until hready is sampled high; bounded so a stuck slave ends the run
	task ahb(input logic w, input logic [7:0] a, input logic [31:0] wd);
		int n;
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {24'h000000, a};
		hwrite <= w;
		n = 0;
		do begin @(posedge ref_clk_i); n++; end while (hreadyout !== 1'b1 && n < 50);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		do begin @(posedge ref_clk_i); n++; end while (hreadyout !== 1'b1 && n < 100);
		rd = hrdata;
		chk(n < 100 && hresp === 1'b0, "bus cycle stuck or not OKAY");
		if (n >= 100) close_out();
	endtask
	task rdchk(input logic [7:0] a, input logic [31:0] e);
		ahb(1'b0, a, 32'h0);
		chk(rd === e, "register read mismatch");
	endtask
	task ctrl(input logic [2:0] st, input logic [4:0] sg, input logic bb, tce, t1, tage);
		ahb(1'b1, `EHC_OFF_CTRL, {12'h000, tage, t1, tce, bb, 3'h0, sg, 5'h00, st});
		exp_st = st;
		exp_sg = sg;
	endtask
	// -------------------------------------------------------------------------
	// Frame helpers
	// -------------------------------------------------------------------------
	task hdr();
		q = {};
		for (int i = 0; i < 12; i++) q.push_back(8'(i + 1));
	endtask
	task p16(input logic [15:0] v);
		q.push_back(v[15:8]);
		q.push_back(v[7:0]);
	endtask
	task llc(input logic [7:0] sap, input logic [7:0] c, input logic [23:0] oui, input logic [15:0] t);
		p16(16'h0026);
		q.push_back(sap);
		q.push_back(sap);
		q.push_back(c);
		p16(oui[23:8]);
		q.push_back(oui[7:0]);
		p16(t);
	endtask
	task run(input int off, input logic m, input logic sl);
		logic [255:0] d;
		int n;
		d = '0;
		for (int i = 0; i < q.size(); i++) d[8*i+:8] = q[i];
		fr_data <= d;
		fr_len <= 6'(q.size());
		fr_slow <= sl;
		fr_go <= 1'b1;
		@(posedge ref_clk_i);
		fr_go <= 1'b0;
		n = 0;
		do begin @(posedge ref_clk_i); n++; end while (rv !== 1'b1 && n < 100);
		chk(n < 100 && mt === m, "match result wrong or missing");
		if (m === 1'b1)
			chk(noff === 8'(off) && nst === exp_st && sgo === exp_sg && fh === exp_fh, "result fields wrong");
		if (n >= 100) close_out();
		// A source that never drains counts as a mismatch, not a silent stop
		while (fr_busy !== 1'b0 && n < 200) begin @(posedge ref_clk_i); n++; end
		chk(fr_busy === 1'b0, "frame source did not finish");
		if (fr_busy !== 1'b0) close_out();
	endtask
	// -------------------------------------------------------------------------
	// Main sequence
	// -------------------------------------------------------------------------
	initial begin
		exp_fh = 8'h00;
		repeat (2) @(posedge ref_clk_i);
		sys_rst_i <= 1'b0;
		@(posedge ref_clk_i);
		rdchk(`EHC_OFF_TPID, 32'h00008A88);
		ahb(1'b1, 8'h20, 32'hFFFFFFFF);
		rdchk(8'h20, 32'h00000000);
		ctrl(3'h5, 5'h11, 1'b0, 1'b0, 1'b0, 1'b0);
		rdchk(`EHC_OFF_CTRL, 32'h00001105);
		hdr(); p16(16'h88F7);
		run(14, 1'b1, 1'b0);
		for (int c = 0; c < 6; c++) begin
			ctrl(3'(c), 5'(31 - c), 1'b0, 1'b0, 1'b0, 1'b0);
			run(14, 1'b1, c[0]);
		end
		ctrl(3'h2, 5'h0E, 1'b0, 1'b1, 1'b0, 1'b0);
		ahb(1'b1, `EHC_OFF_TYPEVAL, 32'h000088F7);
		run(14, 1'b1, 1'b0);
		hdr(); p16(16'h0800);
		run(14, 1'b0, 1'b0);
		hdr(); p16(16'h8100); p16(16'h0123); p16(16'h88F7);
		run(18, 1'b1, 1'b1);
		hdr(); p16(16'h8A88); p16(16'h0001); p16(16'h8100); p16(16'h0123); p16(16'h88F7);
		run(22, 1'b1, 1'b0);
		ahb(1'b1, `EHC_OFF_TPID, 32'h00009100);
		hdr(); p16(16'h9100); p16(16'h0001); p16(16'h88F7);
		run(18, 1'b1, 1'b0);
		hdr(); p16(16'h8A88); p16(16'h0001); p16(16'h88F7);
		run(18, 1'b0, 1'b0);
		ahb(1'b1, `EHC_OFF_TPID, 32'h00008A88);
		ctrl(3'h4, 5'h14, 1'b0, 1'b1, 1'b1, 1'b0);
		hdr(); llc(8'hAA, 8'h03, 24'h000000, 16'h0800);
		run(22, 1'b1, 1'b0);
		hdr(); llc(8'hAB, 8'h03, 24'h0000F8, 16'h88F7);
		run(22, 1'b1, 1'b1);
		// Tag type in the SNAP header: a tag follows, then the final type
		hdr(); llc(8'hAA, 8'h03, 24'h000000, 16'h8100); p16(16'h0123); p16(16'h88F7);
		run(26, 1'b1, 1'b0);
		hdr(); llc(8'hAC, 8'h03, 24'h000000, 16'h88F7);
		run(0, 1'b0, 1'b0);
		hdr(); llc(8'hAA, 8'h02, 24'h000000, 16'h88F7);
		run(0, 1'b0, 1'b0);
		hdr(); llc(8'hAA, 8'h03, 24'h000001, 16'h88F7);
		run(0, 1'b0, 1'b0);
		hdr(); p16(16'h8A88); p16(16'h0001); p16(16'h8100); p16(16'h0123); llc(8'hAA, 8'h03, 24'h0, 16'h88F7);
		run(30, 1'b1, 1'b0);
		ctrl(3'h1, 5'h00, 1'b0, 1'b0, 1'b0, 1'b1);
		ahb(1'b1, `EHC_OFF_TAGCMP, 32'h0FF00120);
		hdr(); p16(16'h8100); p16(16'h0123); p16(16'h88F7);
		run(18, 1'b1, 1'b0);
		ahb(1'b1, `EHC_OFF_TAGCMP, 32'h0FFF0120);
		run(18, 1'b0, 1'b0);
		ctrl(3'h1, 5'h00, 1'b1, 1'b0, 1'b0, 1'b0);
		hdr(); p16(16'h88E7); p16(16'h0000); p16(16'h0100);
		run(18, 1'b1, 1'b0);
		hdr(); p16(16'h8A88); p16(16'h0002); p16(16'h88E7); p16(16'h0000); p16(16'h0100);
		run(22, 1'b1, 1'b1);
		hdr(); p16(16'h0800);
		run(0, 1'b0, 1'b0);
		ctrl(3'h1, 5'h00, 1'b0, 1'b0, 1'b0, 1'b0);
		ahb(1'b1, `EHC_OFF_FLOW_BASE, 32'h8FFF0123);
		ahb(1'b1, 8'h44, 32'h8FFF0456);
		exp_fh = 8'h01;
		hdr(); p16(16'h8100); p16(16'h0123); p16(16'h88F7);
		run(18, 1'b1, 1'b0);
		rdchk(`EHC_OFF_STATUS, 32'h12000101);
		close_out();
	end
endmodule // ethernet_header_next_protocol_cmp_tb
